// *** include/isf_map.vh ***
// Purpose: register offsets, field positions and reset values of the status-flag block
// Assumes: AHB-Lite, 32-bit words, one register per aligned word
// Notes:   offsets are byte addresses
`ifndef ISF_MAP_VH
`define ISF_MAP_VH
`define ISF_OFF_STATUS    8'h00
`define ISF_OFF_CTRL      8'h04
`define ISF_OFF_TXDATA    8'h08
`define ISF_OFF_RXDATA    8'h0c
`define ISF_OFF_IRQ_STAT  8'h10
`define ISF_OFF_IRQ_MASK  8'h14
`define ISF_BIT_WCOL      7
`define ISF_BIT_ROV       6
`define ISF_BIT_DATA      5
`define ISF_BIT_STOP      4
`define ISF_BIT_START     3
`define ISF_BIT_RW        2
`define ISF_BIT_IBF       1
`define ISF_BIT_OBF       0
`define ISF_CTRL_EN       0
`define ISF_IRQ_WCOL      0
`define ISF_IRQ_ROV       1
`define ISF_IRQ_RXDONE    2
`define ISF_IRQ_TXDONE    3
`define ISF_IRQ_STOP      4
`define ISF_IRQ_W         5
`define ISF_RST_STATUS    16'h0000
`define ISF_RST_MASK      5'h00
`define ISF_RST_IRQ       5'h00
`endif

// *** design/isf_status_flags.v ***
// Purpose: status flags of an i2c controller, reached over AHB-Lite
// Assumes: shift logic supplies one-cycle event pulses on the system clock
// Notes:   bus events come from logic on the same clock, so they are not synchronised
// Overview of operation
// - tx write while busy is discarded and sets write collision; software clears it
// - start and stop flags update on each condition; cleared while enable is 0
// - start flag is one when last condition was start or restart, else zero
// - slave direction flag is one for slave read, zero for slave write
// - inbound full set when reception completes; zero while receive register empty
// - outbound full is one while tx register holds a byte being sent
`timescale 1ns/1ps
`include "isf_map.vh"
module isf_status_flags (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        hsel_i,
  input  wire [7:0]  haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire        hreadyout_o,
  output wire        hresp_o,
  output reg  [31:0] hrdata_o,
  input  wire        start_det_i,
  input  wire        stop_det_i,
  input  wire        rx_done_i,
  input  wire [7:0]  rx_byte_i,
  input  wire        slave_addr_i,
  input  wire        slave_read_i,
  input  wire        tx_busy_i,
  input  wire        tx_done_i,
  output reg  [7:0]  tx_byte_o,
  output reg         tx_load_o,
  output wire        module_enable_o,
  output wire        irq_o
);
  reg        ap_valid_reg;
  reg        ap_write_reg;
  reg  [7:0] ap_addr_reg;
  reg        en_reg;
  reg        wcol_reg;
  reg        rov_reg;
  reg        data_reg;
  reg        stop_reg;
  reg        start_reg;
  reg        rw_reg;
  reg        ibf_reg;
  reg        obf_reg;
  reg  [7:0] rx_hold_reg;
  reg  [4:0] irq_stat_reg;
  reg  [4:0] irq_mask_reg;
  reg        ap_valid_next;
  reg        ap_write_next;
  reg  [7:0] ap_addr_next;
  reg        en_next;
  reg  [4:0] irq_mask_next;
  reg        wcol_next;
  reg        rov_next;
  reg        start_next;
  reg        stop_next;
  reg        data_next;
  reg        rw_next;
  reg        ibf_next;
  reg  [7:0] rx_hold_next;
  reg        obf_next;
  reg  [7:0] tx_byte_next;
  reg        tx_load_next;
  wire [4:0]  irq_stat_next;
  wire        rov_set;
  wire [15:0] status_w;
  wire        wr_ph;
  wire        rd_ph;
  wire        tx_wr;
  wire        tx_collide;
  wire        rx_rd;
  wire        stat_wr;
  wire        irq_rd;
  wire [4:0]  irq_ev;

  // no wait states: every register answers in the data phase
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign module_enable_o = en_reg;
  assign wr_ph = ap_valid_reg & ap_write_reg;
  assign rd_ph = ap_valid_reg & ~ap_write_reg;
  assign tx_wr   = wr_ph & (ap_addr_reg == `ISF_OFF_TXDATA);
  // busy means a byte is still loaded or the shifter is running
  assign tx_collide = tx_wr & (tx_busy_i | obf_reg);
  assign rx_rd   = rd_ph & (ap_addr_reg == `ISF_OFF_RXDATA);
  assign stat_wr = wr_ph & (ap_addr_reg == `ISF_OFF_STATUS);
  assign irq_rd  = rd_ph & (ap_addr_reg == `ISF_OFF_IRQ_STAT);

  assign status_w = {8'h00, wcol_reg, rov_reg, data_reg, stop_reg,
                     start_reg, rw_reg, ibf_reg, obf_reg};

  // a read in the same cycle empties the buffer, so no overflow then
  assign rov_set = rx_done_i & en_reg & ibf_reg & ~rx_rd;
  // event bits: stop, tx done, rx done, overflow, write collision
  assign irq_ev = {stop_det_i & en_reg,
                   tx_done_i & en_reg,
                   rx_done_i & en_reg,
                   rov_set,
                   tx_collide};
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // address phase is held for the data phase that follows
  always @* begin
    ap_valid_next = ap_valid_reg;
    ap_write_next = ap_write_reg;
    ap_addr_next  = ap_addr_reg;
    if (hready_i) begin
      ap_valid_next = hsel_i & htrans_i[1];
      ap_write_next = hwrite_i;
      ap_addr_next  = haddr_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg  <= 8'h00;
    end else begin
      ap_valid_reg <= ap_valid_next;
      ap_write_reg <= ap_write_next;
      ap_addr_reg  <= ap_addr_next;
    end
  end

  // enable and interrupt mask are owned by software alone
  always @* begin
    en_next       = en_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_ph & (ap_addr_reg == `ISF_OFF_CTRL))
      en_next = hwdata_i[`ISF_CTRL_EN];
    if (wr_ph & (ap_addr_reg == `ISF_OFF_IRQ_MASK))
      irq_mask_next = hwdata_i[`ISF_IRQ_W-1:0];
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      en_reg       <= 1'b0;
      irq_mask_reg <= `ISF_RST_MASK;
    end else begin
      en_reg       <= en_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // error flags: set wins over the software clear
  always @* begin
    wcol_next = wcol_reg;
    rov_next  = rov_reg;
    if (tx_collide)
      wcol_next = 1'b1;
    else if (stat_wr & ~hwdata_i[`ISF_BIT_WCOL])
      wcol_next = 1'b0;
    if (rov_set)
      rov_next = 1'b1;
    else if (stat_wr & ~hwdata_i[`ISF_BIT_ROV])
      rov_next = 1'b0;
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wcol_reg <= 1'b0;
      rov_reg  <= 1'b0;
    end else begin
      wcol_reg <= wcol_next;
      rov_reg  <= rov_next;
    end
  end

  // bus condition and slave direction flags
  always @* begin
    start_next = start_reg;
    stop_next  = stop_reg;
    data_next  = data_reg;
    rw_next    = rw_reg;
    if (!en_reg) begin
      start_next = 1'b0;
      stop_next  = 1'b0;
      data_next  = 1'b0;
      rw_next    = 1'b0;
    end else begin
      // stop wins if both are seen together: it is the later condition
      if (stop_det_i) begin
        start_next = 1'b0;
        stop_next  = 1'b1;
      end else if (start_det_i) begin
        start_next = 1'b1;
        stop_next  = 1'b0;
      end
      if (rx_done_i) begin
        data_next = ~slave_addr_i;
        if (slave_addr_i)
          rw_next = slave_read_i;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
      data_reg  <= 1'b0;
      rw_reg    <= 1'b0;
    end else begin
      start_reg <= start_next;
      stop_reg  <= stop_next;
      data_reg  <= data_next;
      rw_reg    <= rw_next;
    end
  end

  // overflowing byte is dropped; the unread byte is kept
  always @* begin
    ibf_next     = ibf_reg;
    rx_hold_next = rx_hold_reg;
    if (!en_reg) begin
      ibf_next = 1'b0;
    end else if (rx_done_i & (~ibf_reg | rx_rd)) begin
      ibf_next     = 1'b1;
      rx_hold_next = rx_byte_i;
    end else if (rx_rd) begin
      ibf_next = 1'b0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ibf_reg     <= 1'b0;
      rx_hold_reg <= 8'h00;
    end else begin
      ibf_reg     <= ibf_next;
      rx_hold_reg <= rx_hold_next;
    end
  end

  // a write while busy is refused, so at most one byte waits
  always @* begin
    obf_next     = obf_reg;
    tx_byte_next = tx_byte_o;
    tx_load_next = 1'b0;
    if (!en_reg) begin
      obf_next = 1'b0;
    end else if (tx_wr & ~tx_collide) begin
      obf_next     = 1'b1;
      tx_byte_next = hwdata_i[7:0];
      tx_load_next = 1'b1;
    end else if (tx_done_i) begin
      obf_next = 1'b0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      obf_reg   <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_load_o <= 1'b0;
    end else begin
      obf_reg   <= obf_next;
      tx_byte_o <= tx_byte_next;
      tx_load_o <= tx_load_next;
    end
  end

  // read clears; an event in the same cycle survives
  genvar gi;
  generate
    for (gi = 0; gi < `ISF_IRQ_W; gi = gi + 1) begin : g_irq
      assign irq_stat_next[gi] = irq_rd ? irq_ev[gi] : (irq_stat_reg[gi] | irq_ev[gi]);
    end
  endgenerate

  always @(posedge sys_clk_i) begin
    if (sys_rst_i)
      irq_stat_reg <= `ISF_RST_IRQ;
    else
      irq_stat_reg <= irq_stat_next;
  end

  // unmapped offsets and idle cycles read as zero
  always @* begin
    hrdata_o = 32'h0000_0000;
    if (rd_ph) begin
      case (ap_addr_reg)
        `ISF_OFF_STATUS:   hrdata_o = {16'h0000, status_w};
        `ISF_OFF_CTRL:     hrdata_o = {31'h0, en_reg};
        `ISF_OFF_TXDATA:   hrdata_o = {24'h0, tx_byte_o};
        `ISF_OFF_RXDATA:   hrdata_o = {24'h0, rx_hold_reg};
        `ISF_OFF_IRQ_STAT: hrdata_o = {27'h0, irq_stat_reg};
        `ISF_OFF_IRQ_MASK: hrdata_o = {27'h0, irq_mask_reg};
        default:           hrdata_o = 32'h0000_0000;
      endcase
    end
  end
endmodule // isf_status_flags

// *** tb/isf_monitor.sv ***
// Purpose: port checks for the status-flag block
// Assumes: zero-wait AHB-Lite slave
// Notes:   flags are seen only through reads
`timescale 1ns/1ps
module isf_monitor (
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        hsel_i,
  input wire [7:0]  haddr_i,
  input wire [1:0]  htrans_i,
  input wire        hwrite_i,
  input wire        hready_i,
  input wire        hreadyout_o,
  input wire        hresp_o,
  input wire [31:0] hrdata_o,
  input wire        tx_busy_i,
  input wire        tx_load_o,
  input wire        module_enable_o,
  input wire        irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire tk = hsel_i && htrans_i[1] && hready_i;
  a_ready_high: assert property (hreadyout_o) else $error("wait state seen");
  a_resp_okay: assert property (!hresp_o) else $error("error response seen");
  a_read_idle: assert property (!(tk && !hwrite_i) |=> hrdata_o == 32'h0) else $error("read data outside read");
  a_load_single: assert property (tx_load_o |=> !tx_load_o) else $error("load repeated");
  a_busy_drop: assert property (tk && hwrite_i && haddr_i == 8'h08 && tx_busy_i ##1 tx_busy_i |=> !tx_load_o)
    else $error("write taken while busy");
  a_load_cause: assert property (tx_load_o |-> $past(tk && hwrite_i && haddr_i == 8'h08, 2))
    else $error("load without write");
  a_off_clear: assert property (tk && !hwrite_i && haddr_i == 8'h00 && !module_enable_o ##1 !module_enable_o
    |-> hrdata_o[4:3] == 2'h0) else $error("start or stop set while off");
  a_enable_cause: assert property ($changed(module_enable_o) |-> $past(tk && hwrite_i && haddr_i == 8'h04, 2))
    else $error("enable moved without write");
  cover property (tx_load_o);
  cover property (irq_o);
  cover property ($fell(module_enable_o));
endmodule // isf_monitor
bind isf_status_flags isf_monitor mon_u (.sys_clk_i, .sys_rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .tx_busy_i, .tx_load_o, .module_enable_o, .irq_o);

// *** tb/isf_shift_model.sv ***
// Purpose: far-side shifter, busy for a set time after each load
// Assumes: hold_i of one or more
// Notes:   done pulses once as the count runs out
`timescale 1ns/1ps
module isf_shift_model (
  input  wire       sys_clk_i,
  input  wire       load_i,
  input  wire [7:0] hold_i,
  output wire       busy_o,
  output reg        done_o
);
  reg [7:0] cnt_reg = 8'h00;
  initial done_o = 1'b0;
  assign busy_o = cnt_reg != 8'h00;
  always @(posedge sys_clk_i) begin
    done_o <= cnt_reg == 8'h01 && !load_i;
    if (load_i) cnt_reg <= hold_i;
    else if (busy_o) cnt_reg <= cnt_reg - 8'h01;
  end
endmodule // isf_shift_model

// *** tb/test_i2c_status_flags.sv ***
// Purpose: self-checking bench for the status-flag block
// Assumes: zero-wait slave, one clock
// Notes:   read results are queued and checked by a watcher
`timescale 1ns/1ps
module test_i2c_status_flags;
  reg         clk = 0, rst = 1, hsel = 0, hw = 0, st = 0, sp = 0, rxd = 0, sa = 0, sr = 0, rph = 0;
  reg  [7:0]  ha = 0, rb = 0, hold = 3;
  reg  [1:0]  ht = 0;
  reg  [31:0] wd = 0, r;
  wire [31:0] rd;
  wire [7:0]  tbo;
  wire        rdy, resp, busy, done, load, en, irq;
  integer     bad_count = 0, check_count = 0, seed = 53, cyc = 0, i;
  reg  [31:0] exp_q[$];
  reg  [7:0]  tx_q[$];
  always #2.5 clk = ~clk;
  isf_status_flags dut_u (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(ha), .htrans_i(ht),
    .hwrite_i(hw), .hsize_i(3'h2), .hwdata_i(wd), .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(resp),
    .hrdata_o(rd), .start_det_i(st), .stop_det_i(sp), .rx_done_i(rxd), .rx_byte_i(rb), .slave_addr_i(sa),
    .slave_read_i(sr), .tx_busy_i(busy), .tx_done_i(done), .tx_byte_o(tbo), .tx_load_o(load),
    .module_enable_o(en), .irq_o(irq));
  isf_shift_model far_u (.sys_clk_i(clk), .load_i(load), .hold_i(hold), .busy_o(busy), .done_o(done));
  task check(input [31:0] seen, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (seen !== want) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      hsel <= 1; ht <= 2'h2; ha <= a; hw <= w;
      do @(posedge clk); while (rdy !== 1'b1);
      hsel <= 0; ht <= 2'h0; wd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      exp_q.push_back(e);
      bus(0, a, 32'h0);
    end
  endtask
  task pulse(input [2:0] k);
    begin
      @(posedge clk);
      {rxd, sp, st} <= k;
      @(posedge clk);
      {rxd, sp, st} <= 3'h0;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin bad_count = bad_count + 1; give_verdict; end
    if (rph) check(rd, exp_q.pop_front());
    if (load) check({24'h0, tbo}, {24'h0, tx_q.pop_front()});
    rph <= hsel && ht[1] && !hw && rdy;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    rdc(8'h00, 32'h0);
    rdc(8'h1c, 32'h0);
    bus(1, 8'h04, 32'h1);
    pulse(3'h1);
    rdc(8'h00, 32'h08);
    pulse(3'h2);
    rdc(8'h00, 32'h10);
    $display("condition test done");
    r = $random(seed);
    rb <= r[7:0]; sa <= 1; sr <= 1;
    pulse(3'h4);
    rdc(8'h00, 32'h16);
    rdc(8'h0c, {24'h0, r[7:0]});
    sa <= 0;
    pulse(3'h4);
    pulse(3'h4);
    rdc(8'h00, 32'h76);
    bus(1, 8'h00, 32'h0);
    bus(1, 8'h00, 32'hff);
    rdc(8'h00, 32'h36);
    $display("receive test done");
    r = $random(seed);
    hold <= 8'd20;
    tx_q.push_back(r[7:0]);
    bus(1, 8'h08, {24'h0, r[7:0]});
    bus(1, 8'h08, {24'h0, ~r[7:0]});
    rdc(8'h00, 32'hb7);
    for (i = 0; i < 100 && done !== 1'b1; i = i + 1) @(posedge clk);
    rdc(8'h00, 32'hb6);
    $display("transmit test done");
    check({31'h0, irq}, 32'h0);
    bus(1, 8'h14, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h1);
    rdc(8'h10, 32'h1f);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1, 8'h04, 32'h0);
    rdc(8'h00, 32'h80);
    $display("irq and disable test done");
    repeat (2) @(posedge clk);
    give_verdict;
  end
endmodule // test_i2c_status_flags
